// File: fcu_regs.vh
`ifndef FCU_REGS_VH
`define FCU_REGS_VH
// register indices (printed offsets are not all multiples of four,
// so the printed offset is an index and the byte address is index * 4)
`define FCU_IDX_CONTROL      2'h0
`define FCU_IDX_CONFIG       2'h1
`define FCU_IDX_STATUS       2'h2
// scan_control fields
`define FCU_CTL_ENABLE       0
`define FCU_CTL_IRQEN        1
`define FCU_CTL_SELFRST      7
// scan_config fields
`define FCU_CFG_SEL_LO       0
`define FCU_CFG_MODE_LO      4
// scan_status fields
`define FCU_STA_BUSY         0
`define FCU_STA_PASS         1
// reset values
`define FCU_CONTROL_RST      8'h00
`define FCU_CONFIG_RST       8'h00
`define FCU_STATUS_RST       8'h02
// section select codes
`define FCU_SEL_FLASH        2'h0
`define FCU_SEL_BOOT_PLUS_APPLICATION      2'h1
`define FCU_SEL_BOOT         2'h2
// access mode: priority
`define FCU_MODE_PRIORITY    2'h0
// checksum
`define FCU_CRC_INIT         16'hffff
`define FCU_CRC_POLY         16'h1021
// start latency in clock cycles
`define FCU_START_DLY        2'h3
`endif

// File: fcu_flash_check_unit.v
`timescale 1ns/1ps
`include "fcu_regs.vh"
module fcu_flash_check_unit
#(
   parameter AW = 16                     // flash byte address width
)
(
   input  wire          clk_i,           // 250 mhz clock
   input  wire          rst_i,           // async system reset, high
   // axi4-lite slave
   input  wire [3:0]    s_axi_awaddr,    // write address
   input  wire          s_axi_awvalid,   // write address valid
   output reg           s_axi_awready,   // write address ready
   input  wire [31:0]   s_axi_wdata,     // write data
   input  wire [3:0]    s_axi_wstrb,     // write strobes
   input  wire          s_axi_wvalid,    // write data valid
   output reg           s_axi_wready,    // write data ready
   output reg  [1:0]    s_axi_bresp,     // write response
   output reg           s_axi_bvalid,    // write response valid
   input  wire          s_axi_bready,    // write response ready
   input  wire [3:0]    s_axi_araddr,    // read address
   input  wire          s_axi_arvalid,   // read address valid
   output reg           s_axi_arready,   // read address ready
   output reg  [31:0]   s_axi_rdata,     // read data
   output reg  [1:0]    s_axi_rresp,     // read response
   output reg           s_axi_rvalid,    // read data valid
   input  wire          s_axi_rready,    // read data ready
   // flash byte port
   output reg  [AW-1:0] flash_addr_o,    // byte address
   output reg           flash_rd_o,      // read strobe
   input  wire [7:0]    flash_data_i,    // data, valid cycle after strobe
   input  wire [AW-1:0] flash_end_i,     // last byte of whole flash
   input  wire [AW-1:0] boot_end_i,      // last byte of boot section
   input  wire [AW-1:0] app_end_i,       // last byte of boot+application
   // start-up scan
   input  wire          preboot_en_i,    // pre-boot scan option fuse
   input  wire [1:0]    preboot_sel_i,   // pre-boot section select
   output reg           cpu_release_o,   // normal execution may begin
   output reg           cpu_stall_o,     // priority access halts cpu
   output reg           nmi_o            // sticky fail interrupt request
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_WAIT  = 2'd1;
   localparam ST_READ  = 2'd2;
   localparam ST_DONE  = 2'd3;

   reg          enable;
   reg          irq_en;
   reg  [1:0]   mode;
   reg  [1:0]   sel;
   reg          busy;
   reg          pass;
   reg  [1:0]   state;
   reg  [1:0]   dly;
   reg  [15:0]  crc;
   reg  [15:0]  refsum;
   reg  [AW-1:0] last;
   reg          rd_q;
   reg  [AW-1:0] addr_q;
   reg          boot_phase;
   reg          boot_done;
   reg          aw_hold;
   reg          w_hold;
   reg  [3:0]   aw_q;
   reg  [31:0]  wd_q;
   reg  [3:0]   ws_q;
   wire [3:0]   next_aw;
   wire [31:0]  next_wd;
   wire [3:0]   next_ws;
   wire         wr_go;
   wire [1:0]   wr_idx;
   wire         wr_ok;
   wire [7:0]   wb;
   wire         do_selfrst;
   wire         start;
   reg  [15:0]  next_crc;
   reg  [7:0]   rd_byte;
   integer      i;

   assign next_aw = aw_hold ? aw_q : s_axi_awaddr;
   assign next_wd = w_hold ? wd_q : s_axi_wdata;
   assign next_ws = w_hold ? ws_q : s_axi_wstrb;
   // act once, in the cycle both halves are held and the response is raised
   assign wr_go   = aw_hold & w_hold & ~s_axi_bvalid;
   assign wr_idx  = next_aw[3:2];
   assign wr_ok   = wr_go & next_ws[0] & ~next_aw[1] & ~next_aw[0];
   assign wb      = next_wd[7:0];

   wire ctl_wr = wr_ok & (wr_idx == `FCU_IDX_CONTROL) & ~nmi_o;
   wire cfg_wr = wr_ok & (wr_idx == `FCU_IDX_CONFIG) & ~busy
                 & ~nmi_o;
   assign do_selfrst = ctl_wr & wb[`FCU_CTL_SELFRST]
                       & (~irq_en | ~busy);
   assign start = ctl_wr & wb[`FCU_CTL_ENABLE] & ~do_selfrst;

   // msb first through the ccitt shift register
   always @*
   begin
      next_crc = crc;
      for (i = 7; i >= 0; i = i - 1)
      begin
         if (next_crc[15] ^ flash_data_i[i])
            next_crc = {next_crc[14:0], 1'b0} ^ `FCU_CRC_POLY;
         else
            next_crc = {next_crc[14:0], 1'b0};
      end
   end

   // axi write channel
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         aw_hold       <= 1'b0;
         w_hold        <= 1'b0;
         aw_q          <= 4'h0;
         wd_q          <= 32'h0;
         ws_q          <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         s_axi_awready <= ~aw_hold & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= ~w_hold & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_q    <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_hold <= 1'b1;
            wd_q   <= s_axi_wdata;
            ws_q   <= s_axi_wstrb;
         end
         if (aw_hold & w_hold & ~s_axi_bvalid)
         begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped index answers decode error
            s_axi_bresp  <= (aw_q[3:2] == 2'h3) ? 2'h3 : 2'h0;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // axi read channel
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr[3:2])
               `FCU_IDX_CONTROL:
                  s_axi_rdata <= {30'h0, irq_en, enable};
               `FCU_IDX_CONFIG:
                  s_axi_rdata <= {26'h0, mode, 2'h0, sel};
               `FCU_IDX_STATUS:
                  s_axi_rdata <= {30'h0, pass, busy};
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h3;
               end
            endcase
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // registers and scan engine
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         enable        <= 1'b0;
         irq_en        <= 1'b0;
         mode          <= 2'h0;
         sel           <= 2'h0;
         busy          <= 1'b0;
         pass          <= 1'b1;
         nmi_o         <= 1'b0;
         state         <= ST_IDLE;
         dly           <= 2'h0;
         crc           <= `FCU_CRC_INIT;
         refsum        <= 16'h0;
         last          <= {AW{1'b0}};
         rd_q          <= 1'b0;
         addr_q        <= {AW{1'b0}};
         flash_addr_o  <= {AW{1'b0}};
         flash_rd_o    <= 1'b0;
         boot_phase    <= 1'b1;
         boot_done     <= 1'b0;
         cpu_release_o <= 1'b0;
         cpu_stall_o   <= 1'b0;
      end
      else
      begin
         flash_rd_o <= 1'b0;
         rd_q       <= flash_rd_o;
         addr_q     <= flash_addr_o;
         // start-up scan, caught after reset release
         if (boot_phase & ~boot_done)
         begin
            boot_done <= 1'b1;
            if (preboot_en_i)
            begin
               sel    <= preboot_sel_i;
               mode   <= 2'h1;
               enable <= 1'b1;
               busy   <= 1'b1;
               state  <= ST_WAIT;
               dly    <= 2'h0;
            end
            else
            begin
               boot_phase    <= 1'b0;
               cpu_release_o <= 1'b1;
            end
         end
         if (cfg_wr)
         begin
            mode <= wb[`FCU_CFG_MODE_LO +: 2];
            sel  <= wb[`FCU_CFG_SEL_LO +: 2];
         end
         if (ctl_wr & wb[`FCU_CTL_IRQEN] & ~busy)
            irq_en <= 1'b1;
         if (start)
         begin
            enable <= 1'b1;
            busy   <= 1'b1;
            state  <= ST_WAIT;
            dly    <= 2'h0;
         end
         case (state)
            ST_IDLE:
               cpu_stall_o <= 1'b0;
            ST_WAIT:
            begin
               // scan begins three cycles after the enable write
               dly <= dly + 2'h1;
               if (dly == `FCU_START_DLY - 2'h1)
               begin
                  state        <= ST_READ;
                  cpu_stall_o  <= (mode == `FCU_MODE_PRIORITY);
                  crc          <= `FCU_CRC_INIT;
                  flash_addr_o <= {AW{1'b0}};
                  flash_rd_o   <= 1'b1;
                  case (sel)
                     `FCU_SEL_BOOT_PLUS_APPLICATION: last <= app_end_i;
                     `FCU_SEL_BOOT:    last <= boot_end_i;
                     default:          last <= flash_end_i;
                  endcase
               end
            end
            ST_READ:
            begin
               if (flash_rd_o & (flash_addr_o != last))
               begin
                  flash_addr_o <= flash_addr_o + {{(AW-1){1'b0}}, 1'b1};
                  flash_rd_o   <= 1'b1;
               end
               if (rd_q)
               begin
                  // checksum bytes are kept apart and not folded into the crc
                  if (addr_q == last - {{(AW-2){1'b0}}, 2'h1})
                     refsum[15:8] <= flash_data_i;
                  else if (addr_q == last)
                     refsum[7:0]  <= flash_data_i;
                  if (addr_q + {{(AW-2){1'b0}}, 2'h2} <= last)
                     crc <= next_crc;
                  if (addr_q == last)
                     state <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               state <= ST_IDLE;
               busy  <= 1'b0;
               pass  <= (crc == refsum);
               if ((crc != refsum) & irq_en)
                  nmi_o <= 1'b1;
               if (boot_phase)
               begin
                  boot_phase    <= 1'b0;
                  // a failed start-up scan keeps the cpu held
                  cpu_release_o <= (crc == refsum);
               end
            end
            default:
               state <= ST_IDLE;
         endcase
         if (do_selfrst)
         begin
            // abandons a scan only while irq enable is clear (else ignored when busy); irq enable survives
            enable      <= 1'b0;
            mode        <= 2'h0;
            sel         <= 2'h0;
            busy        <= 1'b0;
            pass        <= 1'b0;
            state       <= ST_IDLE;
            cpu_stall_o <= 1'b0;
            flash_rd_o  <= 1'b0;
         end
      end
   end
endmodule

// File: fcu_flash_check_unit_checker.sv
`timescale 1ns/1ps
module fcu_flash_check_unit_checker
#(
   parameter AW = 16                  // flash addr width
)
(
   input wire          clk_i,         // clock
   input wire          rst_i,         // reset
   input wire [3:0]    s_axi_awaddr,  // aw addr
   input wire          s_axi_awvalid, // aw valid
   input wire          s_axi_awready, // aw ready
   input wire [31:0]   s_axi_wdata,   // w data
   input wire [3:0]    s_axi_wstrb,   // w strobes
   input wire          s_axi_wvalid,  // w valid
   input wire          s_axi_wready,  // w ready
   input wire          s_axi_bvalid,  // b valid
   input wire          s_axi_arvalid, // ar valid
   input wire          s_axi_arready, // ar ready
   input wire [31:0]   s_axi_rdata,   // r data
   input wire          s_axi_rvalid,  // r valid
   input wire          s_axi_rready,  // r ready
   input wire [AW-1:0] flash_addr_o,  // flash addr
   input wire          flash_rd_o,    // flash strobe
   input wire          cpu_stall_o,   // cpu stall
   input wire          cpu_release_o, // cpu released
   input wire          nmi_o          // fail request
);
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
property p_nmi_sticky;
   nmi_o |=> nmi_o;
endproperty
a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi dropped");
property p_rd_upper;
   s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
endproperty
a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
property p_scan_first;
   $rose(flash_rd_o) |-> flash_addr_o == {AW{1'b0}};
endproperty
a_scan_first: assert property (p_scan_first) else $error("not from 0");
property p_scan_step;
   flash_rd_o && $past(flash_rd_o) |-> flash_addr_o == $past(flash_addr_o) + 1;
endproperty
a_scan_step: assert property (p_scan_step) else $error("addr skip");
property p_stall;
   flash_rd_o && cpu_release_o |-> cpu_stall_o;
endproperty
a_stall: assert property (p_stall) else $error("cpu not stalled");
// only a write taken with aw and w together is tied to a start
property p_start;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
   && s_axi_awaddr == 4'h0 && s_axi_wdata[0] && !s_axi_wdata[7]
   && s_axi_wstrb[0] && !nmi_o |-> ##[1:8] flash_rd_o;
endproperty
a_start: assert property (p_start) else $error("scan not started");
property p_bresp;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
   |-> ##2 s_axi_bvalid;
endproperty
a_bresp: assert property (p_bresp) else $error("no write response");
property p_rresp;
   s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
endproperty
a_rresp: assert property (p_rresp) else $error("no read response");
c_nmi: cover property ($rose(nmi_o));
c_scan: cover property ($fell(flash_rd_o));
c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind fcu_flash_check_unit fcu_flash_check_unit_checker #(.AW(AW)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .flash_addr_o(flash_addr_o), .flash_rd_o(flash_rd_o),
   .cpu_stall_o(cpu_stall_o), .cpu_release_o(cpu_release_o),
   .nmi_o(nmi_o));

// File: tb_flash_crc_scan_control.sv
`timescale 1ns/1ps
module tb_flash_crc_scan_control;
   reg          clk_i;
   reg          rst_i;
   reg  [3:0]   awaddr;
   reg          awvalid;
   wire         awready;
   reg  [31:0]  wdata;
   reg  [3:0]   wstrb;
   reg          wvalid;
   wire         wready;
   wire         bvalid;
   reg          bready;
   reg  [3:0]   araddr;
   reg          arvalid;
   wire         arready;
   wire [31:0]  rdata;
   wire [1:0]   rresp;
   wire         rvalid;
   reg          rready;
   wire [7:0]   faddr;
   wire         frd;
   reg  [7:0]   fdata;
   wire         nmi;
   reg          preb;
   reg  [1:0]   pbsel;
   reg  [7:0]   mem [0:63];
   reg  [7:0]   v;
   reg  [1:0]   rr;
   integer      n_errors;
   integer      n_compared;
   integer      cyc;
   integer      i;
   fcu_flash_check_unit #(.AW(8)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .flash_addr_o(faddr), .flash_rd_o(frd),
      .flash_data_i(fdata), .flash_end_i(8'h3f), .boot_end_i(8'h0f),
      .app_end_i(8'h1f), .preboot_en_i(preb), .preboot_sel_i(pbsel),
      .cpu_release_o(), .cpu_stall_o(), .nmi_o(nmi));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (frd)
         fdata <= mem[faddr[5:0]];
   // whole run is under a thousand cycles; ceiling leaves wide margin
   always @(posedge clk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end
   task finish_test;
      begin
         if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [8*5:1] name, input [7:0] exp, input [7:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp)
         begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk_i);
         awaddr <= a;
         wdata <= {24'h0, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do
         begin
            @(posedge clk_i);
            if (awready)
               awvalid <= 1'b0;
            if (wready)
               wvalid <= 1'b0;
         end
         while (bvalid !== 1'b1);
         bready <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, output [7:0] d, output [1:0] r);
      begin
         @(posedge clk_i);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do
         begin
            @(posedge clk_i);
            if (arready)
               arvalid <= 1'b0;
         end
         while (rvalid !== 1'b1);
         d = rdata[7:0];
         r = rresp;
         rready <= 1'b0;
      end
   endtask
   task rdc(input [8*5:1] name, input [3:0] a, input [7:0] e);
      reg [7:0] d;
      reg [1:0] r;
      begin
         rd(a, d, r);
         chk(name, e, d);
      end
   endtask
   // start latency is three cycles, so busy is only polled after that
   task wait_idle;
      begin
         repeat (8) @(posedge clk_i);
         v = 8'h01;
         while (v[0] !== 1'b0)
            rd(4'h8, v, rr);
      end
   endtask
   // reference of each section covers all bytes before it, high first
   task put_ref(input integer last);
      integer k;
      integer j;
      reg [15:0] c;
      begin
         c = 16'hffff;
         for (k = 0; k < last - 1; k = k + 1)
            for (j = 7; j >= 0; j = j - 1)
               c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[k][j]) ? 16'h1021 : 16'h0);
         mem[last - 1] = c[15:8];
         mem[last] = c[7:0];
      end
   endtask
   initial
   begin
      rst_i = 1'b1;
      {awaddr, awvalid, wdata, wvalid, bready} = 0;
      {araddr, arvalid, rready, fdata, preb, pbsel} = 0;
      wstrb = 4'h1;
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      for (i = 0; i < 64; i = i + 1)
         mem[i] = 8'h03 + 8'h07 * i[7:0];
      put_ref(15);
      put_ref(31);
      put_ref(63);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rdc("ctl", 4'h0, 8'h00);
      rdc("cfg", 4'h4, 8'h00);
      rdc("sta", 4'h8, 8'h02);
      rd(4'hc, v, rr);
      chk("rresp", 8'h03, {6'h0, rr});
      for (i = 0; i < 3; i = i + 1)
      begin
         wr(4'h4, i[7:0]);
         wr(4'h0, 8'h01);
         wait_idle;
         rdc("sta", 4'h8, 8'h02);
         rdc("ctl", 4'h0, 8'h01);
         rdc("cfg", 4'h4, i[7:0]);
      end
      wr(4'h0, 8'h00);
      rdc("ctl", 4'h0, 8'h01);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h01);
      rd(4'h8, v, rr);
      chk("busy", 8'h01, {7'h0, v[0]});
      wr(4'h4, 8'h02);
      wait_idle;
      rdc("cfg", 4'h4, 8'h00);
      mem[5] = mem[5] ^ 8'h01;
      wr(4'h4, 8'h02);
      wr(4'h0, 8'h01);
      wait_idle;
      rdc("sta", 4'h8, 8'h00);
      chk("nmi", 8'h00, {7'h0, nmi});
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h80);
      rdc("ctl", 4'h0, 8'h00);
      rdc("cfg", 4'h4, 8'h00);
      rdc("sta", 4'h8, 8'h00);
      mem[5] = mem[5] ^ 8'h01;
      wr(4'h4, 8'h02);
      wr(4'h0, 8'h02);
      rdc("ctl", 4'h0, 8'h02);
      wr(4'h0, 8'h03);
      wr(4'h0, 8'h80);
      wait_idle;
      rdc("ctl", 4'h0, 8'h03);
      rdc("sta", 4'h8, 8'h02);
      mem[5] = mem[5] ^ 8'h01;
      wr(4'h0, 8'h03);
      wait_idle;
      chk("nmi", 8'h01, {7'h0, nmi});
      rdc("sta", 4'h8, 8'h00);
      wr(4'h0, 8'h80);
      rdc("ctl", 4'h0, 8'h03);
      wr(4'h4, 8'h01);
      rdc("cfg", 4'h4, 8'h02);
      // second reset with the start-up scan over the boot section
      mem[5] = mem[5] ^ 8'h01;
      preb <= 1'b1;
      pbsel <= 2'h2;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      wait_idle;
      rdc("ctl", 4'h0, 8'h01);
      rdc("cfg", 4'h4, 8'h12);
      rdc("sta", 4'h8, 8'h02);
      wr(4'h4, 8'h02);
      rdc("cfg", 4'h4, 8'h02);
      finish_test;
   end
endmodule
